/* cpdo_pkg.sv */
/*
 * Package for the compare / PWM / dead-time output stage: register map,
 * field positions, reset values and compare-mode codes.
 * Assumes a 32-bit Avalon-MM slave port and a 16-bit timer counter.
 */
//
// Overview of operation
// - On match, output compare mode holds, sets, clears or toggles the reference.
// - Counter equal to compare value sets the sticky compare flag.
// - Compare interrupt request is raised only when its enable bit is set.
// - DMA request needs DMA enable; a select bit picks match or update event.
// - Update event never changes reference or outputs in output compare mode.
// - Without preload a compare write acts at once; with preload at update.
// - Compare mode codes 110 and 111 select PWM mode 1 and mode 2.
// - PWM mode 1 reference is high while counter is below compare value.
// - Compare above reload holds reference high; compare zero holds it low.
// - PWM is edge-aligned only, counter counts upward.
// - Main and complementary outputs each have their own polarity bit.
// - Dead-time acts when both output enables and master enable are set.
// - Main output rising edge is delayed by dead-time after reference rise.
// - Complementary rising edge is delayed by dead-time after reference fall.
// - A pulse shorter than the dead-time is suppressed completely.
// - One dead-time field is shared by all channels.
// - Dead-time is also inserted when master enable falls to idle.
// - The two enable bits route the reference to main, complementary, or both.
// - Complementary-only output is not inverted; active while reference high.
// - With both enabled, main active on reference high, complementary on low.
// - Compare timing resolution is one counter count.
// - Mode codes force the reference high or low without comparison.
// - Main and complementary outputs are never active together.
package cpdo_pkg;
   // ==========================================================
   // Register word indices (byte address / 4, word index = addr[4:2])
   localparam logic [2:0] CTRL_IDX    = 3'h0;
   localparam logic [2:0] ENABLE_IDX  = 3'h1;
   localparam logic [2:0] DTIME_IDX   = 3'h2;
   localparam logic [2:0] RELOAD_IDX  = 3'h3;
   localparam logic [2:0] COMPARE_IDX = 3'h4;
   localparam logic [2:0] STATUS_IDX  = 3'h5;
   localparam logic [2:0] EVENT_IDX   = 3'h6;
   localparam logic [2:0] COUNT_IDX   = 3'h7;

   // ==========================================================
   // Control register fields
   localparam int MODE_LSB      = 0;
   localparam int PRELOAD_BIT   = 3;
   localparam int RLPRE_BIT     = 4;
   localparam int CNT_EN_BIT    = 5;
   localparam int IRQ_EN_BIT    = 6;
   localparam int DMA_EN_BIT    = 7;
   localparam int DMA_SEL_BIT   = 8;
   // Enable / polarity register fields
   localparam int MAIN_EN_BIT   = 0;
   localparam int MAIN_POL_BIT  = 1;
   localparam int COMP_EN_BIT   = 2;
   localparam int COMP_POL_BIT  = 3;
   localparam int MASTER_EN_BIT = 4;
   // Event register fields (write one to fire)
   localparam int SW_UPD_BIT    = 0;

   // ==========================================================
   // Widths and reset values
   localparam int CNT_W = 16;
   localparam int DT_W  = 10;
   localparam logic [CNT_W-1:0] RELOAD_RST  = 16'hffff;
   localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
   localparam logic [DT_W-1:0]  DTIME_RST   = 10'h000;
   localparam logic [31:0]      UNMAPPED_RD = 32'h0000_0000;

   // ==========================================================
   // Compare mode codes
   localparam logic [2:0] MODE_FROZEN   = 3'h0;
   localparam logic [2:0] MODE_SET      = 3'h1;
   localparam logic [2:0] MODE_CLEAR    = 3'h2;
   localparam logic [2:0] MODE_TOGGLE   = 3'h3;
   localparam logic [2:0] MODE_FORCE_LO = 3'h4;
   localparam logic [2:0] MODE_FORCE_HI = 3'h5;
   localparam logic [2:0] MODE_PWM1     = 3'h6;
   localparam logic [2:0] MODE_PWM2     = 3'h7;
endpackage : cpdo_pkg

/* cpdo_top.sv */
/*
 * Single-channel compare / PWM output stage with dead-time generator,
 * up-counter, preload shadowing and an Avalon-MM register slave.
 * Assumes one 100 MHz clock, synchronous active-high reset, and an
 * Avalon master that holds each request until waitrequest is low.
 */
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module cpdo_top (
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   input  wire logic [4:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic             o_main_output,
   output logic             o_complementary_output,
   output logic             o_compare_irq,
   output logic             o_compare_dma_req
);
   localparam int W = cpdo_pkg::CNT_W;

   // ==========================================================
   // Register bus
   logic [8:0]       ctrl_r;
   logic [4:0]       enable_r;
   logic [cpdo_pkg::DT_W-1:0] deadtime_field_r;
   logic [W-1:0]     reload_pre_r;
   logic [W-1:0]     reload_act_r;
   logic [W-1:0]     compare_pre_r;
   logic [W-1:0]     compare_act_r;
   logic [W-1:0]     counter_value_r;
   logic             compare_flag_r;
   logic             ack_r;
   logic [2:0]       idx;
   logic             wr_go;
   logic             rd_go;
   logic [31:0]      wmask;
   logic [31:0]      wdat;

   assign idx   = i_avs_address[4:2];
   assign wr_go = i_avs_write && !ack_r;
   assign rd_go = i_avs_read && !ack_r;

   // Byte enables expanded per bit lane
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_be
         assign wmask[gb*8 +: 8] = {8{i_avs_byteenable[gb]}};
      end
   endgenerate

   // One wait state: answer comes on the second edge of every request
   // Waitrequest is its own flop, always the inverse of ack, so the pin is registered
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ack_r             <= 1'b0;
         o_avs_waitrequest <= 1'b1;
      end else begin
         ack_r             <= (i_avs_read || i_avs_write) && !ack_r;
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_r);
      end
   end

   logic wr_ctrl;
   logic wr_en;
   logic wr_dt;
   logic wr_rl;
   logic wr_cmp;
   logic wr_st;
   logic wr_ev;
   assign wr_ctrl = wr_go && ack_r == 1'b0 && idx == cpdo_pkg::CTRL_IDX;
   assign wr_en   = wr_go && idx == cpdo_pkg::ENABLE_IDX;
   assign wr_dt   = wr_go && idx == cpdo_pkg::DTIME_IDX;
   assign wr_rl   = wr_go && idx == cpdo_pkg::RELOAD_IDX;
   assign wr_cmp  = wr_go && idx == cpdo_pkg::COMPARE_IDX;
   assign wr_st   = wr_go && idx == cpdo_pkg::STATUS_IDX;
   assign wr_ev   = wr_go && idx == cpdo_pkg::EVENT_IDX;

   // Write data merged with old value per byte lane
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m, input logic [31:0] d);
      merge = (old & ~m) | (d & m);
   endfunction : merge

   // Current value of the addressed word, for the byte-lane merge
   logic [31:0] old_word;
   always_comb begin
      case (idx)
         cpdo_pkg::CTRL_IDX:    old_word = {23'h0, ctrl_r};
         cpdo_pkg::ENABLE_IDX:  old_word = {27'h0, enable_r};
         cpdo_pkg::DTIME_IDX:   old_word = {22'h0, deadtime_field_r};
         cpdo_pkg::RELOAD_IDX:  old_word = {16'h0, reload_pre_r};
         cpdo_pkg::COMPARE_IDX: old_word = {16'h0, compare_pre_r};
         default:               old_word = 32'h0000_0000;
      endcase
   end
   assign wdat = merge(old_word, wmask, i_avs_writedata);

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ctrl_r           <= 9'h000;
         enable_r         <= 5'h00;
         deadtime_field_r <= cpdo_pkg::DTIME_RST;
         reload_pre_r     <= cpdo_pkg::RELOAD_RST;
         compare_pre_r    <= cpdo_pkg::COMPARE_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= wdat[8:0];
         end
         if (wr_en) begin
            enable_r <= wdat[4:0];
         end
         if (wr_dt) begin
            deadtime_field_r <= wdat[cpdo_pkg::DT_W-1:0];
         end
         if (wr_rl) begin
            reload_pre_r <= wdat[W-1:0];
         end
         if (wr_cmp) begin
            compare_pre_r <= wdat[W-1:0];
         end
      end
   end

   logic [2:0] mode;
   logic       cnt_en;
   assign mode   = ctrl_r[cpdo_pkg::MODE_LSB +: 3];
   assign cnt_en = ctrl_r[cpdo_pkg::CNT_EN_BIT];

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_avs_readdata <= cpdo_pkg::UNMAPPED_RD;
      end else if (rd_go) begin
         case (idx)
            cpdo_pkg::CTRL_IDX:    o_avs_readdata <= {23'h0, ctrl_r};
            cpdo_pkg::ENABLE_IDX:  o_avs_readdata <= {27'h0, enable_r};
            cpdo_pkg::DTIME_IDX:   o_avs_readdata <= {22'h0, deadtime_field_r};
            cpdo_pkg::RELOAD_IDX:  o_avs_readdata <= {16'h0, reload_pre_r};
            cpdo_pkg::COMPARE_IDX: o_avs_readdata <= {16'h0, compare_pre_r};
            cpdo_pkg::STATUS_IDX:  o_avs_readdata <= {31'h0, compare_flag_r};
            cpdo_pkg::COUNT_IDX:   o_avs_readdata <= {16'h0, counter_value_r};
            default:               o_avs_readdata <= cpdo_pkg::UNMAPPED_RD;
         endcase
      end
   end

   // ==========================================================
   // Counter, update event and shadows
   logic update_event;
   logic sw_upd;
   logic wrap;
   assign sw_upd       = wr_ev && i_avs_byteenable[0] && i_avs_writedata[cpdo_pkg::SW_UPD_BIT];
   assign wrap         = cnt_en && counter_value_r >= reload_act_r;
   assign update_event = sw_upd || wrap;

   // Up-counting only, hence edge-aligned PWM
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         counter_value_r <= '0;
      end else if (update_event) begin
         counter_value_r <= '0;
      end else if (cnt_en) begin
         counter_value_r <= counter_value_r + 16'h0001;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         compare_act_r <= cpdo_pkg::COMPARE_RST;
         reload_act_r  <= cpdo_pkg::RELOAD_RST;
      end else begin
         if (!ctrl_r[cpdo_pkg::PRELOAD_BIT] || update_event) begin
            compare_act_r <= compare_pre_r;
         end
         if (!ctrl_r[cpdo_pkg::RLPRE_BIT] || update_event) begin
            reload_act_r <= reload_pre_r;
         end
      end
   end

   // ==========================================================
   // Compare match, flag, irq and dma
   logic match;
   assign match = counter_value_r == compare_act_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         compare_flag_r <= 1'b0;
      end else if (match) begin
         compare_flag_r <= 1'b1;
      end else if (wr_st && i_avs_byteenable[0] && !i_avs_writedata[0]) begin
         compare_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_compare_irq     <= 1'b0;
         o_compare_dma_req <= 1'b0;
      end else begin
         o_compare_irq     <= ctrl_r[cpdo_pkg::IRQ_EN_BIT] && (compare_flag_r || match);
         o_compare_dma_req <= ctrl_r[cpdo_pkg::DMA_EN_BIT] &&
                              (ctrl_r[cpdo_pkg::DMA_SEL_BIT] ? update_event : match);
      end
   end

   // ==========================================================
   // Reference waveform
   logic reference_waveform_r;
   logic pwm_active;
   assign pwm_active = counter_value_r < compare_act_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         reference_waveform_r <= 1'b0;
      end else begin
         case (mode)
            // Match-driven modes ignore the update event entirely
            cpdo_pkg::MODE_FROZEN:   reference_waveform_r <= reference_waveform_r;
            cpdo_pkg::MODE_SET:      if (match) reference_waveform_r <= 1'b1;
            cpdo_pkg::MODE_CLEAR:    if (match) reference_waveform_r <= 1'b0;
            cpdo_pkg::MODE_TOGGLE:   if (match) reference_waveform_r <= !reference_waveform_r;
            cpdo_pkg::MODE_FORCE_LO: reference_waveform_r <= 1'b0;
            cpdo_pkg::MODE_FORCE_HI: reference_waveform_r <= 1'b1;
            cpdo_pkg::MODE_PWM1:     reference_waveform_r <= pwm_active;
            cpdo_pkg::MODE_PWM2:     reference_waveform_r <= !pwm_active;
            default:                 reference_waveform_r <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Dead-time generator
   logic                      main_en;
   logic                      comp_en;
   logic                      master_en;
   logic                      both_on;
   logic                      ref_d_r;
   logic                      master_d_r;
   logic [cpdo_pkg::DT_W-1:0] dt_cnt_r;
   logic                      main_act_r;
   logic                      comp_act_r;
   logic                      want_main;
   logic                      want_comp;
   logic                      dt_done;

   assign main_en   = enable_r[cpdo_pkg::MAIN_EN_BIT];
   assign comp_en   = enable_r[cpdo_pkg::COMP_EN_BIT];
   assign master_en = enable_r[cpdo_pkg::MASTER_EN_BIT];
   assign both_on   = main_en && comp_en && master_en;
   // Idle state drives both sides inactive
   assign want_main = master_en && reference_waveform_r;
   assign want_comp = master_en && !reference_waveform_r;
   // Rise allowed exactly deadtime_field cycles after the reference edge; zero means no delay
   assign dt_done   = (ref_d_r != reference_waveform_r) ? (deadtime_field_r == '0) : (dt_cnt_r <= 10'h001);

   // Counter restarts on every reference edge and on master enable fall,
   // so a pulse shorter than the dead-time never reaches an output.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ref_d_r    <= 1'b0;
         master_d_r <= 1'b0;
         dt_cnt_r   <= '0;
      end else begin
         ref_d_r    <= reference_waveform_r;
         master_d_r <= master_en;
         if (ref_d_r != reference_waveform_r || (master_d_r && !master_en)) begin
            dt_cnt_r <= deadtime_field_r;
         end else if (dt_cnt_r != '0) begin
            dt_cnt_r <= dt_cnt_r - 10'h001;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         main_act_r <= 1'b0;
         comp_act_r <= 1'b0;
      end else begin
         // Falling edges pass at once, rising edges wait for the count
         main_act_r <= want_main && (main_act_r || dt_done);
         comp_act_r <= want_comp && (comp_act_r || dt_done);
      end
   end

   // ==========================================================
   // Output routing and polarity
   logic main_lvl;
   logic comp_lvl;
   always_comb begin
      if (both_on) begin
         main_lvl = main_act_r;
         comp_lvl = comp_act_r && !main_act_r;
      end else begin
         main_lvl = main_en && master_en && reference_waveform_r;
         comp_lvl = comp_en && !main_en && master_en && reference_waveform_r;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_main_output          <= 1'b0;
         o_complementary_output <= 1'b0;
      end else begin
         o_main_output          <= main_lvl ^ enable_r[cpdo_pkg::MAIN_POL_BIT];
         o_complementary_output <= comp_lvl ^ enable_r[cpdo_pkg::COMP_POL_BIT];
      end
   end
endmodule : cpdo_top

/* cpdo_assertions.sv */
/* Port checker for cpdo_top, bound below.
   Assumes all byte lanes are enabled on register writes. */
`timescale 1ns/100ps
module cpdo_assertions (
   input wire logic        i_clk_sys,
   input wire logic        i_sys_rst,
   input wire logic [4:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic        o_avs_waitrequest,
   input wire logic        o_main_output,
   input wire logic        o_complementary_output,
   input wire logic        o_compare_irq,
   input wire logic        o_compare_dma_req
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   // ==========
   // Shadows taken on the edge where the slave takes a write
   logic [4:0]  en_r;
   logic [1:0]  ie_r;
   logic [9:0]  dt_r;
   logic [15:0] gap_r;
   logic        tk;
   logic        pol0;
   logic        both;
   assign tk   = i_avs_write & o_avs_waitrequest;
   assign pol0 = !en_r[1] & !en_r[3];
   assign both = en_r[0] & en_r[2] & en_r[4] & pol0;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         en_r <= 5'h00;
         ie_r <= 2'h0;
         dt_r <= 10'h000;
      end else if (tk) begin
         if (i_avs_address[4:2] == cpdo_pkg::ENABLE_IDX) en_r <= i_avs_writedata[4:0];
         if (i_avs_address[4:2] == cpdo_pkg::CTRL_IDX) ie_r <= i_avs_writedata[7:6];
         if (i_avs_address[4:2] == cpdo_pkg::DTIME_IDX) dt_r <= i_avs_writedata[9:0];
      end
   end
   // Saturates so a long idle stretch cannot wrap back to zero
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || o_main_output || o_complementary_output) begin
         gap_r <= 16'h0000;
      end else if (gap_r != 16'hfffe) begin
         gap_r <= gap_r + 16'h0001;
      end
   end
   // ==========
   // Assertions
   a_no_overlap: assert property (pol0 |-> !(o_main_output && o_complementary_output))
      else $error("both outputs active");
   a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("no answer after one wait state");
   a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_irq_gated: assert property (o_compare_irq |-> ie_r[0] || $past(ie_r[0]))
      else $error("irq without enable");
   a_dma_gated: assert property (o_compare_dma_req |-> ie_r[1] || $past(ie_r[1]))
      else $error("dma request without enable");
   a_idle_quiet: assert property ((!en_r[4] && pol0) [*4] |-> !o_main_output && !o_complementary_output)
      else $error("output active while idle");
   // Both-enabled must have stood two edges, so an enable write is not taken for a reference edge
   a_main_dead: assert property ($rose(o_main_output) && both && $past(both) && $past(both, 2)
      |-> {6'h00, dt_r} <= gap_r)
      else $error("main rose before dead time");
   a_comp_dead: assert property ($rose(o_complementary_output) && both && $past(both) && $past(both, 2)
      |-> {6'h00, dt_r} <= gap_r)
      else $error("complementary rose before dead time");
   c_main_rise: cover property ($rose(o_main_output) && both);
   c_irq: cover property (o_compare_irq);
   c_dma: cover property (o_compare_dma_req);
endmodule : cpdo_assertions

bind cpdo_top cpdo_assertions u_chk (
   .i_clk_sys(i_clk_sys),
   .i_sys_rst(i_sys_rst),
   .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata),
   .o_avs_waitrequest(o_avs_waitrequest),
   .o_main_output(o_main_output),
   .o_complementary_output(o_complementary_output),
   .o_compare_irq(o_compare_irq),
   .o_compare_dma_req(o_compare_dma_req)
);

/* cpdo_power_stage.sv */
/* Half-bridge model driven by the two outputs.
   Assumes active-high gate inputs on both switches. */
`timescale 1ns/100ps
module cpdo_power_stage (
   input  wire logic i_clk_sys,
   input  wire logic i_sys_rst,
   input  wire logic i_main,
   input  wire logic i_comp,
   output logic      o_shoot_r
);
   // ==========
   // Both switches on at once shorts the rail; latched for the bench
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_shoot_r <= 1'b0;
      end else if (i_main && i_comp) begin
         o_shoot_r <= 1'b1;
      end
   end
endmodule : cpdo_power_stage

/* compare_pwm_deadtime_output_test.sv */
/* Bench for cpdo_top: PWM table, compare modes, flag, irq, dma, preload.
   Assumes one 100 MHz clock and the power stage model. */
`timescale 1ns/100ps
module compare_pwm_deadtime_output_test;
   typedef struct packed {
      logic [2:0]  mode;
      logic [15:0] cmp;
      logic [4:0]  en;
      logic [9:0]  dt;
      logic [7:0]  em;
      logic [7:0]  ec;
   } cpdo_row_t;
   // ==========
   // Signals
   logic        clk;
   logic        rst;
   logic [4:0]  adr;
   logic        rd_s;
   logic        wr_s;
   logic [31:0] wd;
   logic [31:0] rdat;
   logic        wt;
   logic        mo;
   logic        co;
   logic        irq;
   logic        dma;
   logic        shoot;
   logic [31:0] q;
   logic [7:0]  m;
   logic [7:0]  c;
   logic [7:0]  d;
   int          n_errors;
   int          tests_run;
   int          cyc = 0;
   cpdo_row_t   rows [12];
   cpdo_top dut (
      .i_clk_sys(clk),
      .i_sys_rst(rst),
      .i_avs_address(adr),
      .i_avs_read(rd_s),
      .i_avs_write(wr_s),
      .i_avs_writedata(wd),
      .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat),
      .o_avs_waitrequest(wt),
      .o_main_output(mo),
      .o_complementary_output(co),
      .o_compare_irq(irq),
      .o_compare_dma_req(dma)
   );
   cpdo_power_stage u_load (
      .i_clk_sys(clk),
      .i_sys_rst(rst),
      .i_main(mo),
      .i_comp(co),
      .o_shoot_r(shoot)
   );
   // ==========
   // Tasks
   task automatic bus_op(input logic [2:0] idx, input logic w, input logic [31:0] v, output logic [31:0] r);
      @(posedge clk);
      adr  <= {idx, 2'b00};
      rd_s <= !w;
      wr_s <= w;
      wd   <= v;
      // Request stands until the rising edge that samples waitrequest low
      do @(posedge clk); while (wt);
      r = rdat;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask : bus_op
   task automatic wr(input logic [2:0] idx, input logic [31:0] v);
      logic [31:0] r;
      bus_op(idx, 1'b1, v, r);
   endtask : wr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic meas(input int n);
      m = 8'h00;
      c = 8'h00;
      d = 8'h00;
      repeat (n) begin
         @(negedge clk);
         m = m + {7'h00, mo};
         c = c + {7'h00, co};
         d = d + {7'h00, dma};
      end
   endtask : meas
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // ==========
   // Clock, timeout and sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      adr = 5'h00;
      rd_s = 1'b0;
      wr_s = 1'b0;
      wd = 32'h0;
      n_errors = 0;
      tests_run = 0;
      // Reload 9 gives a 10-cycle period; counts are highs per period
      rows = '{'{3'h6, 16'h3, 5'h11, 10'h0, 8'h3, 8'h0}, '{3'h6, 16'h0, 5'h11, 10'h0, 8'h0, 8'h0},
               '{3'h6, 16'hc, 5'h11, 10'h0, 8'ha, 8'h0}, '{3'h7, 16'h3, 5'h11, 10'h0, 8'h7, 8'h0},
               '{3'h5, 16'h3, 5'h11, 10'h0, 8'ha, 8'h0}, '{3'h4, 16'h3, 5'h11, 10'h0, 8'h0, 8'h0},
               '{3'h6, 16'h3, 5'h14, 10'h0, 8'h0, 8'h3}, '{3'h6, 16'h3, 5'h15, 10'h2, 8'h1, 8'h5},
               '{3'h6, 16'h3, 5'h15, 10'h4, 8'h0, 8'h3}, '{3'h6, 16'h3, 5'h13, 10'h0, 8'h7, 8'h0},
               '{3'h6, 16'h3, 5'h1c, 10'h0, 8'h0, 8'h7}, '{3'h6, 16'h3, 5'h01, 10'h0, 8'h0, 8'h0}};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus_op(3'h3, 1'b0, 32'h0, q);
      check(q, {16'h0000, cpdo_pkg::RELOAD_RST});
      bus_op(3'h2, 1'b0, 32'h0, q);
      check(q, {22'h0, cpdo_pkg::DTIME_RST});
      check({30'h0, mo, co}, 32'h0);
      for (int i = 0; i < 12; i++) begin
         wr(3'h0, {28'h0, 1'b1, rows[i].mode});
         wr(3'h3, 32'h9);
         wr(3'h4, {16'h0, rows[i].cmp});
         wr(3'h2, {22'h0, rows[i].dt});
         wr(3'h1, {27'h0, rows[i].en});
         wr(3'h6, 32'h1);
         wr(3'h0, {26'h0, 3'h5, rows[i].mode});
         repeat (30) @(posedge clk);
         meas(10);
         check({24'h0, m}, {24'h0, rows[i].em});
         check({24'h0, c}, {24'h0, rows[i].ec});
      end
      // Compare match actions with an update in between
      wr(3'h1, 32'h11);
      wr(3'h0, 32'h21);
      repeat (15) @(negedge clk);
      check({31'h0, mo}, 32'h1);
      wr(3'h0, 32'h20);
      wr(3'h6, 32'h1);
      repeat (12) @(negedge clk);
      check({31'h0, mo}, 32'h1);
      wr(3'h0, 32'h22);
      repeat (15) @(negedge clk);
      check({31'h0, mo}, 32'h0);
      wr(3'h0, 32'h23);
      meas(20);
      check({24'h0, m}, 32'ha);
      bus_op(3'h5, 1'b0, 32'h0, q);
      check({31'h0, q[0]}, 32'h1);
      wr(3'h0, 32'h63);
      repeat (3) @(negedge clk);
      check({31'h0, irq}, 32'h1);
      // Stop away from a match, then clear the flag
      wr(3'h0, 32'h43);
      bus_op(3'h7, 1'b0, 32'h0, q);
      // Flip the low bit: stays inside 0..9, so the dma scenarios still see one match a period
      wr(3'h4, q ^ 32'h1);
      wr(3'h5, 32'h0);
      bus_op(3'h5, 1'b0, 32'h0, q);
      check({31'h0, q[0]}, 32'h0);
      check({31'h0, irq}, 32'h0);
      for (int k = 0; k < 3; k++) begin
         wr(3'h0, (k == 0) ? 32'ha3 : (k == 1) ? 32'h1a3 : 32'h23);
         repeat (12) @(posedge clk);
         meas(10);
         check({24'h0, d}, (k == 2) ? 32'h0 : 32'h1);
      end
      check({31'h0, irq}, 32'h0);
      // Preload with the counter stopped
      wr(3'h0, 32'h0e);
      wr(3'h6, 32'h1);
      bus_op(3'h7, 1'b0, 32'h0, q);
      wr(3'h4, q + 32'h1);
      wr(3'h6, 32'h1);
      repeat (5) @(negedge clk);
      check({31'h0, mo}, 32'h1);
      wr(3'h4, q);
      repeat (5) @(negedge clk);
      check({31'h0, mo}, 32'h1);
      wr(3'h6, 32'h1);
      repeat (5) @(negedge clk);
      check({31'h0, mo}, 32'h0);
      wr(3'h0, 32'h06);
      wr(3'h4, q + 32'h1);
      repeat (5) @(negedge clk);
      check({31'h0, mo}, 32'h1);
      check({31'h0, shoot}, 32'h0);
      tally_and_finish();
   end
endmodule : compare_pwm_deadtime_output_test
